/* File: design/tda_analyzer.sv */
// What this block does
// - start-stop characters carry 5, 6, 7 or 8 data levels per selector
// - sync selector position treats input as continuous bit stream, no framing
// - polarity setting inverts sampled input before framing and measuring
// - line-mark output follows the conditioned input being Mark
// - bit timing from selectable internal rate, range A 37.5 to 9600 baud
// - range setting picks range A or range B rate table
// - reversal mode counts mismatches against alternating mark/space
// - pseudo-random mode counts mismatches against local sequence
// - parity mode counts 8-level characters whose parity fails
// - peak mode reports largest transition displacement, both framings
// - bias mode measures marking versus spacing lengthening, both framings
// - end mode averages character end transitions, start-stop only
// - all position includes every transition in measurement
// - numbered position measures only that transition of each character
// - distortion modes read out percent of unit interval, 0 to 50
// - error modes read out accumulated error count, 0 to 50
// - error counter stops at 50 with sticky overflow until manual clear
`timescale 1ns/1ps
`include "tda_defines.svh"
module tda_analyzer (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic line_in,
  input wire logic ext_time_base,
  output logic line_mark,
  output logic [5:0] readout,
  output logic overflow,
  output logic marking
);
  function automatic logic [11:0] rate_div(input logic rb, input logic [3:0] sel);
    int b;
    b = `TDA_BAUD10_A9;
    if (!rb)
    begin
      case (sel)
        4'h0: b = `TDA_BAUD10_A0;
        4'h1: b = `TDA_BAUD10_A1;
        4'h2: b = `TDA_BAUD10_A2;
        4'h3: b = `TDA_BAUD10_A3;
        4'h4: b = `TDA_BAUD10_A4;
        4'h5: b = `TDA_BAUD10_A5;
        4'h6: b = `TDA_BAUD10_A6;
        4'h7: b = `TDA_BAUD10_A7;
        4'h8: b = `TDA_BAUD10_A8;
        default: b = `TDA_BAUD10_A9;
      endcase
    end
    else
    begin
      case (sel)
        4'h0: b = `TDA_BAUD10_B0;
        4'h1: b = `TDA_BAUD10_B1;
        4'h2: b = `TDA_BAUD10_B2;
        4'h3: b = `TDA_BAUD10_B3;
        4'h4: b = `TDA_BAUD10_B4;
        default: b = `TDA_BAUD10_B5;
      endcase
    end
    // rates are kept in tenths of a baud so 37.5 stays exact
    return 12'(`TDA_CLK_HZ * 10 / (`TDA_TICKS_PER_BIT * b));
  endfunction

  function automatic logic [5:0] avg6(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] s;
    s = 7'(a) + 7'(b);
    return s[6:1];
  endfunction

  // register bus
  tda_pkg::tda_ctrl_t ctrl_r, ctrl_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_fire, clr;
  logic [31:0] word;
  tda_pkg::tda_status_t status_r, status_nxt;

  assign s_axi_awready = ce & ~aw_held_r;
  assign s_axi_wready = ce & ~w_held_r;
  assign s_axi_arready = ce & ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign clr = wr_fire && {awaddr_r[7:2], 2'b00} == `TDA_ADDR_CLEAR &&
    wstrb_r[0] && wdata_r[`TDA_CLEAR_BIT];

  always_comb
  begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    word = {15'h0000, ctrl_r};
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (wr_fire)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `TDA_RESP_OKAY;
      if ({awaddr_r[7:2], 2'b00} == `TDA_ADDR_CTRL)
      begin
        for (int i = 0; i < 3; i++)
          if (wstrb_r[i])
            word[8*i +: 8] = wdata_r[8*i +: 8];
        ctrl_nxt = tda_pkg::tda_ctrl_t'(word[`TDA_CTRL_W-1:0]);
      end
      else if ({awaddr_r[7:2], 2'b00} != `TDA_ADDR_CLEAR)
        bresp_nxt = `TDA_RESP_SLVERR;
    end
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `TDA_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if ({s_axi_araddr[7:2], 2'b00} == `TDA_ADDR_CTRL)
        rdata_nxt = {15'h0000, ctrl_r};
      else if ({s_axi_araddr[7:2], 2'b00} == `TDA_ADDR_STATUS)
        rdata_nxt = {23'h00_0000, status_r};
      else if ({s_axi_araddr[7:2], 2'b00} != `TDA_ADDR_CLEAR)
        rresp_nxt = `TDA_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= tda_pkg::tda_ctrl_t'(`TDA_CTRL_RST);
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `TDA_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TDA_RESP_OKAY;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // time base and measurement
  tda_pkg::tda_frame_t frame_r, frame_nxt;
  logic [11:0] tb_cnt_r, tb_cnt_nxt, div;
  logic ext_d_r, prev_r, aligned_r, aligned_nxt, rev_r, rev_nxt, ovf_r, ovf_nxt, mark_r, mark_nxt;
  logic [7:0] phase_r, phase_nxt, char_r, char_nxt, disp;
  logic [3:0] bit_r, bit_nxt, nbits, bnd;
  logic [8:0] lfsr_r, lfsr_nxt;
  logic [5:0] peak_r, peak_nxt, bias_r, bias_nxt, end_r, end_nxt, err_r, err_nxt, pct;
  logic tick, cond, edge_ev, is_sync, late, incl, bit_ev, err_ev;

  assign cond = line_in ^ ctrl_r.polarity_invert_select;
  assign is_sync = ctrl_r.level >= tda_pkg::lvl_sync;
  assign nbits = 4'(ctrl_r.level) + 4'h5;
  assign div = rate_div(ctrl_r.range_b, ctrl_r.rate_sel);
  // external ticks are its rising edges, one per two-hundredth of a bit
  assign tick = ctrl_r.external_time_base_select ? (ext_time_base & ~ext_d_r) :
    (tb_cnt_r >= div - 12'h001);
  assign edge_ev = cond != prev_r;
  assign late = phase_r < `TDA_HALF;
  assign disp = late ? phase_r : `TDA_TICKS - phase_r;
  assign pct = disp[6:1];
  assign bnd = late ? bit_r : bit_r + 4'h1;
  assign incl = (frame_r == tda_pkg::fr_sync && aligned_r) ||
    (frame_r == tda_pkg::fr_char && (ctrl_r.trans_sel == 4'h0 ||
    ctrl_r.trans_sel == bnd));

  always_comb
  begin
    frame_nxt = frame_r;
    phase_nxt = phase_r;
    bit_nxt = bit_r;
    char_nxt = char_r;
    aligned_nxt = aligned_r;
    lfsr_nxt = lfsr_r;
    rev_nxt = rev_r;
    peak_nxt = peak_r;
    bias_nxt = bias_r;
    end_nxt = end_r;
    mark_nxt = mark_r;
    err_nxt = err_r;
    ovf_nxt = ovf_r;
    tb_cnt_nxt = (tick || ctrl_r.external_time_base_select) ? 12'h000 : tb_cnt_r + 12'h001;
    bit_ev = 1'b0;
    err_ev = 1'b0;
    case (frame_r)
      tda_pkg::fr_idle:
      begin
        phase_nxt = 8'h00;
        bit_nxt = 4'h0;
        if (is_sync)
          frame_nxt = tda_pkg::fr_sync;
        else if (edge_ev && !cond)
          frame_nxt = tda_pkg::fr_char;
      end
      tda_pkg::fr_char:
      begin
        if (is_sync)
          frame_nxt = tda_pkg::fr_sync;
        else if (tick)
        begin
          phase_nxt = (phase_r == `TDA_TICKS - 8'h01) ? 8'h00 : phase_r + 8'h01;
          bit_nxt = (phase_r == `TDA_TICKS - 8'h01) ? bit_r + 4'h1 : bit_r;
          if (phase_r == `TDA_HALF - 8'h01)
          begin
            // a start element that reads Mark at its centre is a glitch
            if (bit_r == 4'h0 && cond)
              frame_nxt = tda_pkg::fr_idle;
            else if (bit_r != 4'h0 && bit_r <= nbits)
            begin
              bit_ev = 1'b1;
              char_nxt = {cond, char_r[7:1]};
            end
            else if (bit_r > nbits)
            begin
              frame_nxt = tda_pkg::fr_idle;
              err_ev = ctrl_r.mode == tda_pkg::md_parity &&
                ctrl_r.level == tda_pkg::lvl_8 && ^char_r;
            end
          end
        end
      end
      default:
      begin
        bit_nxt = 4'h0;
        if (!is_sync)
          frame_nxt = tda_pkg::fr_idle;
        else if (edge_ev && !aligned_r)
        begin
          // first edge after a clear sets the bit-cell phase, no later resync
          phase_nxt = 8'h00;
          aligned_nxt = 1'b1;
        end
        else if (tick)
        begin
          phase_nxt = (phase_r == `TDA_TICKS - 8'h01) ? 8'h00 : phase_r + 8'h01;
          bit_ev = aligned_r && phase_r == `TDA_HALF - 8'h01;
        end
      end
    endcase
    if (bit_ev)
    begin
      rev_nxt = ~rev_r;
      lfsr_nxt = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
      if (ctrl_r.mode == tda_pkg::reversal_pattern_mode && cond != rev_r)
        err_ev = 1'b1;
      if (ctrl_r.mode == tda_pkg::pseudo_random_mode && cond != lfsr_r[8])
        err_ev = 1'b1;
    end
    if (edge_ev && incl)
    begin
      if (pct > peak_r)
        peak_nxt = pct;
      bias_nxt = avg6(bias_r, pct);
      mark_nxt = late ^ cond;
      if (frame_r == tda_pkg::fr_char && cond && bnd == nbits + 4'h1)
        end_nxt = avg6(end_r, pct);
    end
    if (err_ev && err_r != `TDA_ERR_MAX)
      err_nxt = err_r + 6'h01;
    if (err_ev && err_r == `TDA_ERR_MAX - 6'h01)
      ovf_nxt = 1'b1;
    if (clr)
    begin
      // an error in the clearing cycle still counts
      err_nxt = err_ev ? 6'h01 : 6'h00;
      ovf_nxt = 1'b0;
      peak_nxt = 6'h00;
      bias_nxt = 6'h00;
      end_nxt = 6'h00;
      mark_nxt = 1'b0;
      aligned_nxt = 1'b0;
      rev_nxt = 1'b1;
      lfsr_nxt = `TDA_LFSR_SEED;
    end
    status_nxt.line_mark = cond;
    status_nxt.overflow = ovf_nxt;
    status_nxt.marking = mark_nxt;
    case (ctrl_r.mode)
      tda_pkg::md_peak: status_nxt.readout = peak_nxt;
      tda_pkg::md_bias: status_nxt.readout = bias_nxt;
      tda_pkg::md_end: status_nxt.readout = end_nxt;
      tda_pkg::reversal_pattern_mode, tda_pkg::pseudo_random_mode,
      tda_pkg::md_parity: status_nxt.readout = err_nxt;
      default: status_nxt.readout = 6'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      frame_r <= tda_pkg::fr_idle;
      tb_cnt_r <= 12'h000;
      ext_d_r <= 1'b0;
      prev_r <= 1'b1;
      phase_r <= 8'h00;
      bit_r <= 4'h0;
      char_r <= 8'h00;
      aligned_r <= 1'b0;
      lfsr_r <= `TDA_LFSR_SEED;
      rev_r <= 1'b1;
      peak_r <= 6'h00;
      bias_r <= 6'h00;
      end_r <= 6'h00;
      mark_r <= 1'b0;
      err_r <= 6'h00;
      ovf_r <= 1'b0;
      status_r <= '0;
    end
    else if (ce)
    begin
      frame_r <= frame_nxt;
      tb_cnt_r <= tb_cnt_nxt;
      ext_d_r <= ext_time_base;
      prev_r <= cond;
      phase_r <= phase_nxt;
      bit_r <= bit_nxt;
      char_r <= char_nxt;
      aligned_r <= aligned_nxt;
      lfsr_r <= lfsr_nxt;
      rev_r <= rev_nxt;
      peak_r <= peak_nxt;
      bias_r <= bias_nxt;
      end_r <= end_nxt;
      mark_r <= mark_nxt;
      err_r <= err_nxt;
      ovf_r <= ovf_nxt;
      status_r <= status_nxt;
    end
  end

  assign line_mark = status_r.line_mark;
  assign readout = status_r.readout;
  assign overflow = status_r.overflow;
  assign marking = status_r.marking;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_line_mark_follow: assert property (ce |=> line_mark == $past(cond))
    else $error("line mark does not follow input");
  a_polarity_sense: assert property (ce && ctrl_r.polarity_invert_select ##1 1 |->
    line_mark == !$past(line_in)) else $error("inverted polarity not applied");
  a_sync_framing: assert property (is_sync && ce ##1 is_sync |-> frame_r == tda_pkg::fr_sync)
    else $error("sync input framed as characters");
  a_char_length: assert property (frame_r == tda_pkg::fr_char |-> bit_r <= nbits + 4'h1)
    else $error("character runs past its stop element");
  a_phase_range: assert property (phase_r < `TDA_TICKS)
    else $error("bit-cell phase out of range");
  a_readout_range: assert property (readout <= `TDA_ERR_MAX)
    else $error("readout above 50");
  a_err_step: assert property (ce && !clr |=> err_r == $past(err_r) ||
    err_r == $past(err_r) + 6'h01) else $error("error count jumped");
  a_ovf_sticky: assert property (ovf_r && !clr |=> ovf_r)
    else $error("overflow dropped without clear");
  a_ovf_at_max: assert property ($rose(ovf_r) |-> err_r == `TDA_ERR_MAX)
    else $error("overflow set below 50");
  a_peak_hold: assert property (ce && !clr |=> peak_r >= $past(peak_r))
    else $error("peak value decreased");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  c_overflow: cover property ($rose(ovf_r));
  c_char_done: cover property (frame_r == tda_pkg::fr_char ##1 frame_r == tda_pkg::fr_idle);
  c_sync_measure: cover property (frame_r == tda_pkg::fr_sync && edge_ev && incl);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: design/tda_defines.svh */
`ifndef TDA_DEFINES_SVH
`define TDA_DEFINES_SVH
`define TDA_CLK_HZ 25000000
`define TDA_TICKS_PER_BIT 200
`define TDA_TICKS 8'hc8
`define TDA_HALF 8'h64
`define TDA_ERR_MAX 6'h32
`define TDA_ADDR_CTRL 8'h00
`define TDA_ADDR_STATUS 8'h04
`define TDA_ADDR_CLEAR 8'h08
`define TDA_CTRL_RST 17'h0_0000
`define TDA_CTRL_W 17
`define TDA_CLEAR_BIT 0
`define TDA_LFSR_SEED 9'h1ff
`define TDA_RESP_OKAY 2'h0
`define TDA_RESP_SLVERR 2'h2
`define TDA_BAUD10_A0 375
`define TDA_BAUD10_A1 500
`define TDA_BAUD10_A2 750
`define TDA_BAUD10_A3 1500
`define TDA_BAUD10_A4 3000
`define TDA_BAUD10_A5 6000
`define TDA_BAUD10_A6 12000
`define TDA_BAUD10_A7 24000
`define TDA_BAUD10_A8 48000
`define TDA_BAUD10_A9 96000
`define TDA_BAUD10_B0 1100
`define TDA_BAUD10_B1 1345
`define TDA_BAUD10_B2 2000
`define TDA_BAUD10_B3 18000
`define TDA_BAUD10_B4 36000
`define TDA_BAUD10_B5 72000
`endif

/* File: design/tda_pkg.sv */
package tda_pkg;
  typedef enum logic [2:0] {md_peak, md_bias, md_end, reversal_pattern_mode,
    pseudo_random_mode, md_parity} tda_mode_t;
  typedef enum logic [2:0] {lvl_5, lvl_6, lvl_7, lvl_8, lvl_sync} tda_level_t;
  typedef enum logic [1:0] {fr_idle, fr_char, fr_sync} tda_frame_t;
  typedef struct packed {
    logic [3:0] trans_sel;
    logic external_time_base_select;
    logic [3:0] rate_sel;
    logic range_b;
    logic polarity_invert_select;
    tda_level_t level;
    tda_mode_t mode;
  } tda_ctrl_t;
  typedef struct packed {
    logic marking;
    logic line_mark;
    logic overflow;
    logic [5:0] readout;
  } tda_status_t;
endpackage

/* File: verif/tda_line_model.sv */
`timescale 1ns/1ps
module tda_line_model (
  input wire logic clk_sys,
  output logic line_in,
  output logic ext_time_base
);
  initial
  begin
    line_in = 1'b1;
    ext_time_base = 1'b0;
  end
  // time base runs free: one rising edge every two clocks, so a bit cell is 400 clocks
  always @(posedge clk_sys)
  begin
    ext_time_base <= ~ext_time_base;
  end
  task automatic hold(input logic lvl, input int ticks);
    line_in <= lvl;
    repeat (2 * ticks) @(posedge clk_sys);
  endtask
  // skew lengthens the start element, so every later transition lands that many ticks late
  task automatic send_char(input logic [7:0] d, input int n, input int skew);
    hold(1'b0, 200 + skew);
    for (int i = 0; i < n; i++)
    begin
      hold(d[i], 200);
    end
    hold(1'b1, 400);
  endtask
endmodule

/* File: verif/tda_analyzer_tb.sv */
`timescale 1ns/1ps
`include "tda_defines.svh"
module tda_analyzer_tb;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] data;
    logic [1:0] resp;
  } tda_note_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic line_in, ext_time_base, line_mark, overflow, marking;
  logic [5:0] readout;
  logic [31:0] seed = 32'h65fb_7a2c;
  tda_note_t rq[$];
  logic [1:0] bq[$];
  tda_note_t n;
  int miscompares = 0;
  int check_count = 0;
  int cnt;
  logic [8:0] pr;
  logic [7:0] chars [3] = '{8'h01, 8'h03, 8'h07};

  always #20 clk_sys = ~clk_sys;

  tda_analyzer u_tda_analyzer (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .line_in(line_in), .ext_time_base(ext_time_base), .line_mark(line_mark),
    .readout(readout), .overflow(overflow), .marking(marking));
  tda_line_model u_tda_line_model (.clk_sys(clk_sys), .line_in(line_in),
    .ext_time_base(ext_time_base));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [31:0] mk(input tda_pkg::tda_mode_t m,
    input tda_pkg::tda_level_t l, input logic p);
    tda_pkg::tda_ctrl_t c;
    c = '0;
    c.mode = m;
    c.level = l;
    c.polarity_invert_select = p;
    c.external_time_base_select = 1'b1;
    return {15'h0000, c};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // address and data offered together, each dropped once its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, sa, sw;
    @(posedge clk_sys);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(negedge clk_sys);
      sa = awready;
      sw = wready;
      @(posedge clk_sys);
      if (aw && sa)
      begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && sw)
      begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    sa = 1'b0;
    while (!sa)
    begin
      @(negedge clk_sys);
      sa = bvalid;
      @(posedge clk_sys);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
    input logic [1:0] r);
    logic hs;
    @(posedge clk_sys);
    rq.push_back('{m, d, r});
    araddr <= a;
    arvalid <= 1'b1;
    hs = 1'b0;
    while (!hs)
    begin
      @(negedge clk_sys);
      hs = arready;
      @(posedge clk_sys);
    end
    arvalid <= 1'b0;
    hs = 1'b0;
    while (!hs)
    begin
      @(negedge clk_sys);
      hs = rvalid;
      @(posedge clk_sys);
    end
  endtask

  // each response is matched with the oldest note left by the driver
  always @(posedge clk_sys)
  begin
    if (rvalid)
    begin
      n = rq.pop_front();
      chk("rdata", rdata & n.mask, n.data & n.mask);
      chk("rresp", {30'h0000_0000, rresp}, {30'h0000_0000, n.resp});
    end
    if (bvalid)
      chk("bresp", {30'h0000_0000, bresp}, {30'h0000_0000, bq.pop_front()});
  end

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`TDA_ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000, `TDA_RESP_OKAY);
    rd(`TDA_ADDR_STATUS, 32'hffff_ffff, 32'h0000_0080, `TDA_RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr(`TDA_ADDR_CTRL, {seed[31:3], i[2:0]}, `TDA_RESP_OKAY);
      rd(`TDA_ADDR_CTRL, 32'hffff_ffff, {15'h0000, seed[16:3], i[2:0]}, `TDA_RESP_OKAY);
    end
    seed = xs(seed);
    rd({seed[7:4] | 4'h4, 4'h0}, 32'hffff_ffff, 32'h0000_0000, `TDA_RESP_SLVERR);
    wr(8'h0c, seed, `TDA_RESP_SLVERR);
    rd(`TDA_ADDR_CLEAR, 32'hffff_ffff, 32'h0000_0000, `TDA_RESP_OKAY);
    $display("test registers done");

    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_peak, tda_pkg::lvl_5, 1'b1), `TDA_RESP_OKAY);
    rd(`TDA_ADDR_STATUS, 32'h0000_0080, 32'h0000_0000, `TDA_RESP_OKAY);
    // with the clock enable low the line change must not reach the indication
    ce <= 1'b0;
    u_tda_line_model.hold(1'b0, 2);
    chk("line_mark frozen", {31'h0000_0000, line_mark}, 32'h0000_0000);
    ce <= 1'b1;
    rd(`TDA_ADDR_STATUS, 32'h0000_0080, 32'h0000_0080, `TDA_RESP_OKAY);
    chk("line_mark", {31'h0000_0000, line_mark}, 32'h0000_0001);
    u_tda_line_model.hold(1'b1, 2);
    $display("test polarity done");

    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_peak, tda_pkg::lvl_5, 1'b0), `TDA_RESP_OKAY);
    // a frame opened by the polarity flips aborts at its start centre before the clear
    u_tda_line_model.hold(1'b1, 200);
    wr(`TDA_ADDR_CLEAR, 32'h0000_0001, `TDA_RESP_OKAY);
    u_tda_line_model.send_char(8'h05, 5, 21);
    // 21 ticks late on a 200-tick cell reads as 10 percent
    rd(`TDA_ADDR_STATUS, 32'h0000_003f, 32'h0000_000a, `TDA_RESP_OKAY);
    chk("readout", {26'h000_0000, readout}, 32'h0000_000a);
    // five late transitions of 10 percent average to 9; only the stop edge ends the char
    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_bias, tda_pkg::lvl_5, 1'b0), `TDA_RESP_OKAY);
    rd(`TDA_ADDR_STATUS, 32'h0000_003f, 32'h0000_0009, `TDA_RESP_OKAY);
    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_end, tda_pkg::lvl_5, 1'b0), `TDA_RESP_OKAY);
    rd(`TDA_ADDR_STATUS, 32'h0000_003f, 32'h0000_0005, `TDA_RESP_OKAY);
    // a late rise to Mark stretches the space before it
    chk("marking", {31'h0000_0000, marking}, 32'h0000_0000);
    $display("test peak done");

    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_parity, tda_pkg::lvl_8, 1'b0), `TDA_RESP_OKAY);
    wr(`TDA_ADDR_CLEAR, 32'h0000_0001, `TDA_RESP_OKAY);
    cnt = 0;
    foreach (chars[i])
    begin
      u_tda_line_model.send_char(chars[i], 8, 0);
      cnt = cnt + int'(^chars[i]);
    end
    rd(`TDA_ADDR_STATUS, 32'h0000_007f, cnt, `TDA_RESP_OKAY);
    $display("test parity done");

    wr(`TDA_ADDR_CTRL, mk(tda_pkg::pseudo_random_mode, tda_pkg::lvl_sync, 1'b0),
      `TDA_RESP_OKAY);
    wr(`TDA_ADDR_CLEAR, 32'h0000_0001, `TDA_RESP_OKAY);
    // one Space cell then 19 Mark cells, twenty bit centres in all
    u_tda_line_model.hold(1'b0, 200);
    u_tda_line_model.hold(1'b1, 3800);
    // leaving sync freezes the count well before the next bit centre
    wr(`TDA_ADDR_CTRL, mk(tda_pkg::md_parity, tda_pkg::lvl_8, 1'b0), `TDA_RESP_OKAY);
    cnt = 0;
    pr = `TDA_LFSR_SEED;
    for (int i = 0; i < 20; i++)
    begin
      cnt = cnt + int'(pr[8] != (i != 0));
      pr = {pr[7:0], pr[8] ^ pr[4]};
    end
    rd(`TDA_ADDR_STATUS, 32'h0000_007f, cnt, `TDA_RESP_OKAY);
    $display("test pseudo-random done");

    wr(`TDA_ADDR_CTRL, mk(tda_pkg::reversal_pattern_mode, tda_pkg::lvl_sync, 1'b0),
      `TDA_RESP_OKAY);
    wr(`TDA_ADDR_CLEAR, 32'h0000_0001, `TDA_RESP_OKAY);
    // steady Mark after one edge misses the alternating expectation on every other bit
    u_tda_line_model.hold(1'b0, 200);
    u_tda_line_model.hold(1'b1, 24000);
    rd(`TDA_ADDR_STATUS, 32'h0000_007f, {25'h0, 1'b1, `TDA_ERR_MAX}, `TDA_RESP_OKAY);
    chk("overflow", {31'h0000_0000, overflow}, 32'h0000_0001);
    wr(`TDA_ADDR_CLEAR, 32'h0000_0001, `TDA_RESP_OKAY);
    rd(`TDA_ADDR_STATUS, 32'h0000_0040, 32'h0000_0000, `TDA_RESP_OKAY);
    $display("test reversal overflow done");
    close_out();
  end
endmodule
